// >>> src/pmc_pkg.sv
package pmc_pkg;

   // ****************************************************
   // Clock and timing
   // ****************************************************
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned BLANK_TIME_NS = 20_000_000;
   localparam int unsigned LATCH_IGNORE_NS = 2_000_000;
   localparam int unsigned SPIKE_TIME_NS = 25_000;
   localparam int unsigned OVP_QUAL_NS = 120_000;
   localparam int unsigned SHORT_QUAL_NS = 190;

   // Least times round up to whole cycles
   localparam int unsigned BLANK_CYC =
      (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LATCH_IGNORE_CYC =
      (LATCH_IGNORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SPIKE_CYC =
      (SPIKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OVP_QUAL_CYC =
      (OVP_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SHORT_QUAL_CYC =
      (SHORT_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Wide enough for every long count above
   localparam int unsigned CNT_W = 24;

   // ****************************************************
   // Comparator decision bit positions
   // ****************************************************
   localparam int unsigned CMP_N = 12;
   localparam int unsigned CMP_FB_LOW = 0;
   localparam int unsigned CMP_FB_HIGH = 1;
   localparam int unsigned CMP_WAKE = 2;
   localparam int unsigned CMP_SLEEP = 3;
   localparam int unsigned CMP_VCC_OV = 4;
   localparam int unsigned CMP_BL_HIGH = 5;
   localparam int unsigned CMP_SHORT = 6;
   localparam int unsigned CMP_BL_LATCH = 7;
   localparam int unsigned CMP_OVER_TEMP = 8;
   localparam int unsigned CMP_VCC_LOW = 9;
   localparam int unsigned CMP_VCC_ON = 10;
   localparam int unsigned CMP_VCC_RESET = 11;

   // ****************************************************
   // Operating modes
   // ****************************************************
   typedef enum logic [2:0] {
      MODE_WAIT,
      MODE_STARTUP,
      MODE_NORMAL,
      MODE_BURST,
      MODE_RESTART,
      MODE_LATCHED
   } pmc_mode_t;

endpackage

// >>> src/pmc_cmp_if.sv
`timescale 1ns/1ps
interface pmc_cmp_if;
   import pmc_pkg::*;

   // Synchronised comparator decisions
   logic [CMP_N-1:0] dec;

   modport sync (output dec);
   modport core (input dec);
endinterface

// >>> src/pmc_sync_bank.sv
`timescale 1ns/1ps
module pmc_sync_bank
   import pmc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [CMP_N-1:0] rawCmp,
   pmc_cmp_if.sync cmpOut
);

   // ****************************************************
   // Two-stage synchronisers, one per comparator
   // ****************************************************
   logic [CMP_N-1:0] meta_q;
   logic [CMP_N-1:0] sync_q;

   genvar i;
   generate
      for (i = 0; i < CMP_N; i++) begin : g_sync
         always_ff @(posedge clk_sys) begin
            if (!resetn) begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end else begin
               meta_q[i] <= rawCmp[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign cmpOut.dec = sync_q;

endmodule // pmc_sync_bank

// >>> src/pmc_qual_filter.sv
`timescale 1ns/1ps
module pmc_qual_filter #(
   parameter int unsigned CYCLES = 1
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic level,
   output logic qualified
);

   // ****************************************************
   // Level must hold for CYCLES clocks before it passes
   // ****************************************************
   localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [W-1:0] CMAX = W'(CYCLES - 1);

   logic [W-1:0] cnt_q;
   logic qual_q;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cnt_q <= '0;
      end else if (!level) begin
         cnt_q <= '0;
      end else if (cnt_q != CMAX) begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   // Any dropout restarts the wait, so short spikes never pass
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         qual_q <= 1'b0;
      end else begin
         qual_q <= level && (cnt_q == CMAX);
      end
   end

   assign qualified = qual_q;

endmodule // pmc_qual_filter

// >>> src/pmc_mode_ctrl.sv
`timescale 1ns/1ps
module pmc_mode_ctrl
   import pmc_pkg::*;
#(
   parameter int unsigned BLANK_CYCLES = BLANK_CYC,
   parameter int unsigned LATCH_IGNORE_CYCLES = LATCH_IGNORE_CYC,
   parameter int unsigned OVP_QUAL_CYCLES = OVP_QUAL_CYC
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic fbWindowLow,
   input wire logic fbWindowHigh,
   input wire logic burstWakeCmp,
   input wire logic burstSleepCmp,
   input wire logic supplyOvCmp,
   input wire logic blankPinHighCmp,
   input wire logic shortFaultCmp,
   input wire logic extLatchLowCmp,
   input wire logic overTempCmp,
   input wire logic vccBelowOffCmp,
   input wire logic vccAboveOnCmp,
   input wire logic vccBelowResetCmp,
   input wire logic softStartDone,
   output logic biasEn_q,
   output logic switchEn_q,
   output logic reducedLimitGate_q,
   output logic startupCellOn_q,
   output logic blankClampOn_q,
   output logic burstFlag_q,
   output logic [2:0] modeState_q
);

   // ****************************************************
   // Input synchronisation
   // ****************************************************
   pmc_cmp_if cmpBus ();

   logic [CMP_N-1:0] rawCmp;

   always_comb begin
      rawCmp = '0;
      rawCmp[CMP_FB_LOW] = fbWindowLow;
      rawCmp[CMP_FB_HIGH] = fbWindowHigh;
      rawCmp[CMP_WAKE] = burstWakeCmp;
      rawCmp[CMP_SLEEP] = burstSleepCmp;
      rawCmp[CMP_VCC_OV] = supplyOvCmp;
      rawCmp[CMP_BL_HIGH] = blankPinHighCmp;
      rawCmp[CMP_SHORT] = shortFaultCmp;
      rawCmp[CMP_BL_LATCH] = extLatchLowCmp;
      rawCmp[CMP_OVER_TEMP] = overTempCmp;
      rawCmp[CMP_VCC_LOW] = vccBelowOffCmp;
      rawCmp[CMP_VCC_ON] = vccAboveOnCmp;
      rawCmp[CMP_VCC_RESET] = vccBelowResetCmp;
   end

   // Every comparator crosses into the clock domain here
   pmc_sync_bank u_sync (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .rawCmp(rawCmp),
      .cmpOut(cmpBus.sync)
   );

   logic fbLow;
   logic fbHigh;
   logic wake;
   logic sleep;
   logic vccLow;
   logic vccOn;
   logic vccReset;

   assign fbLow = cmpBus.dec[CMP_FB_LOW];
   assign fbHigh = cmpBus.dec[CMP_FB_HIGH];
   assign wake = cmpBus.dec[CMP_WAKE];
   assign sleep = cmpBus.dec[CMP_SLEEP];
   assign vccLow = cmpBus.dec[CMP_VCC_LOW];
   assign vccOn = cmpBus.dec[CMP_VCC_ON];
   assign vccReset = cmpBus.dec[CMP_VCC_RESET];

   // ****************************************************
   // Fault qualification filters
   // ****************************************************
   logic ovSpikeOk;
   logic ovQualified;
   logic tempQualified;
   logic shortQualified;
   logic pinChargedOk;
   logic pinChargeLevel;

   // Spike filter first, then the longer persistence
   pmc_qual_filter #(.CYCLES(SPIKE_CYC)) u_ovSpike (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .level(cmpBus.dec[CMP_VCC_OV]),
      .qualified(ovSpikeOk)
   );

   // Overvoltage must persist for its qualification time
   pmc_qual_filter #(.CYCLES(OVP_QUAL_CYCLES)) u_ovQual (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .level(ovSpikeOk),
      .qualified(ovQualified)
   );

   // Temperature trip through the same spike filter
   pmc_qual_filter #(.CYCLES(SPIKE_CYC)) u_tempSpike (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .level(cmpBus.dec[CMP_OVER_TEMP]),
      .qualified(tempQualified)
   );

   // Short level must hold 190 ns, rounded up to whole cycles
   pmc_qual_filter #(.CYCLES(SHORT_QUAL_CYC)) u_shortQual (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .level(cmpBus.dec[CMP_SHORT]),
      .qualified(shortQualified)
   );

   // Pin counts as charged only once the clamp is open
   assign pinChargeLevel = cmpBus.dec[CMP_BL_HIGH] && !blankClampOn_q;

   pmc_qual_filter #(.CYCLES(SPIKE_CYC)) u_pinSpike (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .level(pinChargeLevel),
      .qualified(pinChargedOk)
   );

   // ****************************************************
   // Mode state
   // ****************************************************
   pmc_mode_t state_q;
   pmc_mode_t state_d;
   logic burstOn_q;
   logic burstOn_d;
   logic uvloSeen_q;
   logic cellHyst_q;
   logic [CNT_W-1:0] blankCnt_q;
   logic [CNT_W-1:0] sinceStart_q;
   logic blankDone;
   logic latchArmed;
   logic latchFault;
   logic running;

   localparam logic [CNT_W-1:0] BLANK_END = CNT_W'(BLANK_CYCLES);
   localparam logic [CNT_W-1:0] LATCH_END = CNT_W'(LATCH_IGNORE_CYCLES);

   assign blankDone = (blankCnt_q == BLANK_END);
   assign latchArmed = (sinceStart_q == LATCH_END);
   assign running = (state_q == MODE_STARTUP) ||
                    (state_q == MODE_NORMAL) ||
                    (state_q == MODE_BURST);

   // Any of these ends in the latched state
   assign latchFault = ovQualified ||
                       tempQualified ||
                       shortQualified ||
                       (cmpBus.dec[CMP_BL_LATCH] && latchArmed);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         MODE_WAIT, MODE_RESTART: begin
            // A fresh lockout cycle must pass before switching resumes
            if (uvloSeen_q && vccOn) begin
               state_d = MODE_STARTUP;
            end
         end
         MODE_STARTUP: begin
            if (latchFault) begin
               state_d = MODE_LATCHED;
            end else if (vccLow) begin
               state_d = MODE_RESTART;
            end else if (softStartDone) begin
               state_d = MODE_NORMAL;
            end
         end
         MODE_NORMAL: begin
            if (latchFault) begin
               state_d = MODE_LATCHED;
            end else if (vccLow) begin
               state_d = MODE_RESTART;
            end else if (fbHigh && pinChargedOk) begin
               state_d = MODE_RESTART;
            end else if (fbLow && blankDone) begin
               state_d = MODE_BURST;
            end
         end
         MODE_BURST: begin
            if (latchFault) begin
               state_d = MODE_LATCHED;
            end else if (vccLow) begin
               state_d = MODE_RESTART;
            end else if (fbHigh) begin
               state_d = MODE_NORMAL;
            end
         end
         MODE_LATCHED: begin
            // Nothing but a deep supply drop releases it
            if (vccReset) begin
               state_d = MODE_WAIT;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_q <= MODE_WAIT;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************************
   // Burst on/off hysteresis
   // ****************************************************
   always_comb begin
      burstOn_d = 1'b0;
      if (state_d == MODE_BURST && state_q == MODE_BURST) begin
         if (wake) begin
            burstOn_d = 1'b1;
         end else if (sleep) begin
            burstOn_d = 1'b0;
         end else begin
            burstOn_d = burstOn_q;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         burstOn_q <= 1'b0;
      end else begin
         burstOn_q <= burstOn_d;
      end
   end

   // ****************************************************
   // Blanking counter
   // ****************************************************
   // Disabled until soft start ends, zero while feedback is in range
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         blankCnt_q <= '0;
      end else if (state_q != MODE_NORMAL || !softStartDone) begin
         blankCnt_q <= '0;
      end else if (!(fbLow || fbHigh)) begin
         blankCnt_q <= '0;
      end else if (!blankDone) begin
         blankCnt_q <= blankCnt_q + CNT_W'(1);
      end
   end

   // Clamp opens only after full blanking under overload
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         blankClampOn_q <= 1'b1;
      end else begin
         blankClampOn_q <= !(state_d == MODE_NORMAL && fbHigh && blankDone);
      end
   end

   // ****************************************************
   // Start-up age, for the external latch request
   // ****************************************************
   // Early pin noise during start-up must not latch the part off
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sinceStart_q <= '0;
      end else if (!running) begin
         sinceStart_q <= '0;
      end else if (!latchArmed) begin
         sinceStart_q <= sinceStart_q + CNT_W'(1);
      end
   end

   // ****************************************************
   // Undervoltage lockout tracking
   // ****************************************************
   // Power-on reset comes from lockout, so the first start needs no dip
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         uvloSeen_q <= 1'b1;
      end else if (state_d == MODE_RESTART && state_q != MODE_RESTART) begin
         uvloSeen_q <= vccLow;
      end else if (vccLow) begin
         uvloSeen_q <= 1'b1;
      end
   end

   // Cell on below turn-off level, off above turn-on level
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cellHyst_q <= 1'b1;
      end else if (vccLow) begin
         cellHyst_q <= 1'b1;
      end else if (vccOn) begin
         cellHyst_q <= 1'b0;
      end
   end

   // ****************************************************
   // Registered outputs
   // ****************************************************
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         biasEn_q <= 1'b0;
         switchEn_q <= 1'b0;
      end else begin
         unique case (state_d)
            MODE_STARTUP, MODE_NORMAL: begin
               biasEn_q <= 1'b1;
               switchEn_q <= !vccLow;
            end
            MODE_BURST: begin
               biasEn_q <= burstOn_d;
               switchEn_q <= burstOn_d && !vccLow;
            end
            default: begin
               biasEn_q <= 1'b0;
               switchEn_q <= 1'b0;
            end
         endcase
      end
   end

   // Low limit only while bursting; full current restored on exit
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         reducedLimitGate_q <= 1'b0;
         burstFlag_q <= 1'b0;
      end else begin
         reducedLimitGate_q <= (state_d == MODE_BURST);
         burstFlag_q <= (state_d == MODE_BURST);
      end
   end

   // Cell is never on while running or bursting; it would waste power
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         startupCellOn_q <= 1'b1;
      end else begin
         unique case (state_d)
            MODE_WAIT, MODE_RESTART, MODE_LATCHED: begin
               startupCellOn_q <= vccLow || (cellHyst_q && !vccOn);
            end
            default: begin
               startupCellOn_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         modeState_q <= 3'(MODE_WAIT);
      end else begin
         modeState_q <= 3'(state_d);
      end
   end

endmodule // pmc_mode_ctrl

// >>> dv/pmc_mode_checker.sv
`timescale 1ns/1ps
// ****************************************************
// Mode control checker
// ****************************************************
module pmc_mode_checker
   import pmc_pkg::*;
#(
   parameter int unsigned BLANK_CYCLES = BLANK_CYC
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic fbWindowLow,
   input wire logic fbWindowHigh,
   input wire logic burstWakeCmp,
   input wire logic burstSleepCmp,
   input wire logic supplyOvCmp,
   input wire logic blankPinHighCmp,
   input wire logic shortFaultCmp,
   input wire logic extLatchLowCmp,
   input wire logic overTempCmp,
   input wire logic vccBelowOffCmp,
   input wire logic vccAboveOnCmp,
   input wire logic vccBelowResetCmp,
   input wire logic softStartDone,
   input wire logic biasEn_q,
   input wire logic switchEn_q,
   input wire logic reducedLimitGate_q,
   input wire logic startupCellOn_q,
   input wire logic blankClampOn_q,
   input wire logic burstFlag_q,
   input wire logic [2:0] modeState_q
);
   logic [31:0] lowRun_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // Run length of low feedback, so burst entry can be bounded from below
   always_ff @(posedge clk_sys) begin
      if (!resetn || !fbWindowLow) begin
         lowRun_q <= 32'h0;
      end else begin
         lowRun_q <= lowRun_q + 32'h1;
      end
   end

   sequence seq_wake_held;
      (modeState_q == 3'h3 && burstWakeCmp && !vccBelowOffCmp) [*3];
   endsequence
   sequence seq_latched_quiet;
      !vccBelowResetCmp [*3] ##0 modeState_q == 3'h5;
   endsequence
   sequence seq_short_held;
      (shortFaultCmp && modeState_q == 3'h2) [*8];
   endsequence

   AST_BURST_BLANKED: assert property ($rose(burstFlag_q) |->
      $past(lowRun_q, 2) >= BLANK_CYCLES) else $error("burst entered early");
   AST_BURST_FLAGS: assert property (modeState_q == 3'h3 |->
      burstFlag_q && reducedLimitGate_q) else $error("burst flags missing");
   AST_BURST_ENTRY_BIAS: assert property ($rose(burstFlag_q) |->
      !biasEn_q && !switchEn_q) else $error("bias on at burst entry");
   AST_BURST_CELL_OFF: assert property (modeState_q == 3'h3 |->
      !startupCellOn_q) else $error("start-up cell on in burst");
   AST_BURST_WAKE: assert property (seq_wake_held |=>
      biasEn_q && switchEn_q) else $error("burst wake ignored");
   AST_FULL_LIMIT: assert property (
      (modeState_q == 3'h3 && fbWindowHigh) [*3] |=>
      !reducedLimitGate_q && modeState_q != 3'h3)
      else $error("burst not left on high feedback");
   AST_LATCH_HOLDS: assert property (seq_latched_quiet |=>
      modeState_q == 3'h5 && !switchEn_q) else $error("latch released");
   AST_LATCH_CELL: assert property (
      (modeState_q == 3'h5 && vccBelowOffCmp) [*3] |=> startupCellOn_q)
      else $error("lockout cell off while latched");
   AST_UVLO_GATE_LOW: assert property (vccBelowOffCmp [*3] |=>
      !switchEn_q) else $error("gate drive under lockout");
   AST_SHORT_LATCH: assert property (seq_short_held |->
      ##[1:8] modeState_q == 3'h5) else $error("short did not latch");
endmodule // pmc_mode_checker

bind pmc_mode_ctrl pmc_mode_checker #(.BLANK_CYCLES(BLANK_CYCLES)) u_chk (
   .clk_sys(clk_sys), .resetn(resetn), .fbWindowLow(fbWindowLow),
   .fbWindowHigh(fbWindowHigh), .burstWakeCmp(burstWakeCmp),
   .burstSleepCmp(burstSleepCmp), .supplyOvCmp(supplyOvCmp),
   .blankPinHighCmp(blankPinHighCmp), .shortFaultCmp(shortFaultCmp),
   .extLatchLowCmp(extLatchLowCmp), .overTempCmp(overTempCmp),
   .vccBelowOffCmp(vccBelowOffCmp), .vccAboveOnCmp(vccAboveOnCmp),
   .vccBelowResetCmp(vccBelowResetCmp), .softStartDone(softStartDone),
   .biasEn_q(biasEn_q), .switchEn_q(switchEn_q),
   .reducedLimitGate_q(reducedLimitGate_q),
   .startupCellOn_q(startupCellOn_q), .blankClampOn_q(blankClampOn_q),
   .burstFlag_q(burstFlag_q), .modeState_q(modeState_q)
);

// >>> dv/pmc_stage_model.sv
`timescale 1ns/1ps
// ****************************************************
// Blanking pin network
// ****************************************************
module pmc_stage_model #(
   parameter int unsigned CHARGE_CYCLES = 30
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic blankClampOn,
   input wire logic pullLow,
   output logic blankPinHigh,
   output logic extLatchLow
);
   logic [15:0] charge_q;

   // Extension capacitor charges only once the clamp lets go
   always_ff @(posedge clk_sys) begin
      if (!resetn || blankClampOn || pullLow) begin
         charge_q <= 16'h0;
      end else if (charge_q < CHARGE_CYCLES) begin
         charge_q <= charge_q + 16'h1;
      end
   end
   assign blankPinHigh = !pullLow && (charge_q >= CHARGE_CYCLES);
   // External transistor drags the pin below the latch level
   assign extLatchLow = pullLow;
endmodule // pmc_stage_model

// >>> dv/test_power_mode_control_unit.sv
`timescale 1ns/1ps
module test_power_mode_control_unit;
   import pmc_pkg::*;
   typedef struct packed {
      logic wake;
      logic sleep;
      logic high;
      logic [8:0] exp;
   } pmc_row_t;
   localparam int unsigned BLANK_T = 50;
   // Wake beats sleep; with neither, the previous burst phase holds
   pmc_row_t rows [6] = '{'{1'b1, 1'b0, 1'b0, 9'h1db},
      '{1'b0, 1'b1, 1'b0, 9'h05b}, '{1'b1, 1'b1, 1'b0, 9'h1db},
      '{1'b0, 1'b0, 1'b0, 9'h1db}, '{1'b0, 1'b1, 1'b0, 9'h05b},
      '{1'b1, 1'b0, 1'b1, 9'h192}};
   int pulseLen [4] = '{900, 900, 5, 0};
   logic clk_sys = 1'b0, resetn = 1'b0, softStartDone = 1'b1;
   logic fbWindowLow = 1'b0, fbWindowHigh = 1'b0, burstWakeCmp = 1'b0;
   logic burstSleepCmp = 1'b0, vccBelowOffCmp = 1'b1, vccAboveOnCmp = 1'b0;
   logic vccBelowResetCmp = 1'b0;
   logic [3:0] faultSel = 4'h0;
   logic blankPinHighCmp, extLatchLowCmp, biasEn_q, switchEn_q, burstFlag_q;
   logic reducedLimitGate_q, startupCellOn_q, blankClampOn_q;
   logic [2:0] modeState_q;
   logic [8:0] outs;
   int nErrors = 0, nCompared = 0, i;

   assign outs = {biasEn_q, switchEn_q, reducedLimitGate_q, startupCellOn_q,
      blankClampOn_q, burstFlag_q, modeState_q};
   always #12.5 clk_sys = ~clk_sys;

   pmc_mode_ctrl #(.BLANK_CYCLES(BLANK_T), .LATCH_IGNORE_CYCLES(20),
      .OVP_QUAL_CYCLES(10)) uut (
      .clk_sys(clk_sys), .resetn(resetn), .fbWindowLow(fbWindowLow),
      .fbWindowHigh(fbWindowHigh), .burstWakeCmp(burstWakeCmp),
      .burstSleepCmp(burstSleepCmp), .supplyOvCmp(faultSel[0]),
      .blankPinHighCmp(blankPinHighCmp), .shortFaultCmp(faultSel[2]),
      .extLatchLowCmp(extLatchLowCmp), .overTempCmp(faultSel[1]),
      .vccBelowOffCmp(vccBelowOffCmp), .vccAboveOnCmp(vccAboveOnCmp),
      .vccBelowResetCmp(vccBelowResetCmp), .softStartDone(softStartDone),
      .biasEn_q(biasEn_q), .switchEn_q(switchEn_q),
      .reducedLimitGate_q(reducedLimitGate_q),
      .startupCellOn_q(startupCellOn_q), .blankClampOn_q(blankClampOn_q),
      .burstFlag_q(burstFlag_q), .modeState_q(modeState_q));

   pmc_stage_model model (.clk_sys(clk_sys), .resetn(resetn),
      .blankClampOn(blankClampOn_q), .pullLow(faultSel[3]),
      .blankPinHigh(blankPinHighCmp), .extLatchLow(extLatchLowCmp));

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      nCompared++;
      if (seen !== exp) begin
         nErrors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Ends just after an edge so outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wait_mode(input pmc_mode_t m, input int lim);
      int k;
      k = 0;
      while (modeState_q !== m && k < lim) begin
         cyc(1);
         k++;
      end
   endtask

   task automatic complete_run;
      if (nErrors == 0 && nCompared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      cyc(1);
      check(outs, 9'h030);
      @(posedge clk_sys);
      resetn <= 1'b1;
      vccBelowOffCmp <= 1'b0;
      vccAboveOnCmp <= 1'b1;
      wait_mode(MODE_NORMAL, 100);
      check(outs, 9'h192);
      @(posedge clk_sys);
      fbWindowLow <= 1'b1;
      cyc(BLANK_T - 5);
      check(9'(modeState_q), 9'(MODE_NORMAL));
      wait_mode(MODE_BURST, 20);
      check(outs, 9'h05b);
      @(posedge clk_sys);
      fbWindowLow <= 1'b0;
      foreach (rows[r]) begin
         @(posedge clk_sys);
         burstWakeCmp <= rows[r].wake;
         burstSleepCmp <= rows[r].sleep;
         fbWindowHigh <= rows[r].high;
         cyc(6);
         check(outs, rows[r].exp);
      end
      // Overload keeps feedback high, so the clamp must let go first
      i = 0;
      while (blankClampOn_q !== 1'b0 && i < 100) begin
         cyc(1);
         i++;
      end
      check(9'(blankClampOn_q), 9'h0);
      cyc(20);
      check(9'(modeState_q), 9'(MODE_NORMAL));
      wait_mode(MODE_RESTART, 1200);
      check({modeState_q, 4'h0, switchEn_q, biasEn_q}, 9'h100);
      @(posedge clk_sys);
      fbWindowHigh <= 1'b0;
      burstWakeCmp <= 1'b0;
      vccBelowOffCmp <= 1'b1;
      vccAboveOnCmp <= 1'b0;
      cyc(6);
      check(9'(startupCellOn_q), 9'h1);
      @(posedge clk_sys);
      vccBelowOffCmp <= 1'b0;
      vccAboveOnCmp <= 1'b1;
      wait_mode(MODE_NORMAL, 100);
      check(outs, 9'h192);
      @(posedge clk_sys);
      vccBelowOffCmp <= 1'b1;
      wait_mode(MODE_RESTART, 20);
      check(9'({modeState_q, switchEn_q}), 9'h8);
      // Latching faults: short pulse ignored (none on the latch pin), held level latches off
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys);
         vccBelowOffCmp <= 1'b0;
         vccAboveOnCmp <= 1'b1;
         faultSel <= (k == 3) ? 4'h8 : 4'h0;
         cyc(12);
         wait_mode(MODE_NORMAL, 100);
         check(9'(modeState_q), 9'(MODE_NORMAL));
         @(posedge clk_sys);
         faultSel <= 4'h0;
         // Pulse stands one edge longer than its count, still short of filter
         if (pulseLen[k] > 0) begin
            @(posedge clk_sys);
            faultSel <= 4'(1 << k);
            cyc(pulseLen[k]);
            @(posedge clk_sys);
            faultSel <= 4'h0;
            cyc(4);
            check(9'(modeState_q), 9'(MODE_NORMAL));
         end
         @(posedge clk_sys);
         faultSel <= 4'(1 << k);
         wait_mode(MODE_LATCHED, 1100);
         check(9'(modeState_q), 9'(MODE_LATCHED));
         @(posedge clk_sys);
         faultSel <= 4'h0;
         vccBelowOffCmp <= 1'b1;
         vccAboveOnCmp <= 1'b0;
         cyc(6);
         check(9'(startupCellOn_q), 9'h1);
         @(posedge clk_sys);
         vccBelowOffCmp <= 1'b0;
         vccAboveOnCmp <= 1'b1;
         cyc(6);
         check(outs, 9'h015);
         @(posedge clk_sys);
         vccBelowOffCmp <= 1'b1;
         vccAboveOnCmp <= 1'b0;
         vccBelowResetCmp <= 1'b1;
         wait_mode(MODE_WAIT, 10);
         check(9'(modeState_q), 9'(MODE_WAIT));
         @(posedge clk_sys);
         vccBelowResetCmp <= 1'b0;
      end
      complete_run();
   end

   // Whole run is under a few hundred microseconds
   initial begin
      #1_000_000;
      nErrors++;
      complete_run();
   end
endmodule // test_power_mode_control_unit
